// ==== hdl/tsc_pkg.sv ====
// package of constants and types for the touch sensor serial client
// ****************************************************************
// Contract
// - works with bus clock up to 400kHz
// - clock low over 30ms resets protocol
// - both lines high over 200us resets protocol
// - timeouts disabled until timeout bit set
// - alert response address is never answered
// - plain multi-byte transfers, no count byte
// - write byte: address, register, data, stop
// - read byte: pointer write, restart, read
// - pointer-only write loads pointer, no data
// - read without pointer uses current pointer
// - pointer advances after each read byte, wraps; code advances only after acked read bytes
// - pointer advances after each written byte, wraps
// - device acks each received byte, ninth clock
// - stop resets client state for next transfer
// ****************************************************************
package tsc_pkg;
    // own 7-bit client address
    localparam logic [6:0] TSC_DEV_ADDR = 7'h28;
    // clock rate in kHz
    localparam int TSC_CLK_KHZ = 25000;
    // clock-low timeout in ms and idle time in us
    localparam int TSC_LOW_TIMEOUT_MS = 30;
    localparam int TSC_IDLE_TIMEOUT_US = 200;
    // cycle counts derived from the rate
    localparam int TSC_LOW_CYCLES = TSC_LOW_TIMEOUT_MS * TSC_CLK_KHZ;
    localparam int TSC_IDLE_CYCLES = TSC_IDLE_TIMEOUT_US * TSC_CLK_KHZ / 1000;
    localparam int TSC_CNT_W = 20;
    localparam logic [3:0] TSC_ACK_BIT = 4'h8;
    localparam logic [7:0] TSC_PTR_RESET = 8'h00;
    // register file access strobe bundle
    typedef struct packed {
        logic wrEn;  // one-cycle write strobe
        logic rdEn;  // fetch strobe, held through address and send phases
        logic [7:0] addr;  // register address
        logic [7:0] wdata;  // write data
    } tsc_reg_req_t;
    // protocol states, one-hot
    typedef enum logic [4:0] {
        TSC_IDLE = 5'h01,
        TSC_ADDR = 5'h02,
        TSC_RXB = 5'h04,
        TSC_TXB = 5'h08,
        TSC_SKIP = 5'h10
    } tsc_state_t;
endpackage

// ==== hdl/tsc_client.sv ====
// two-wire serial client that reaches an 8-bit register space
`timescale 1ns/100ps
module tsc_client
    import tsc_pkg::*;
#(
    parameter int LOW_CYCLES = TSC_LOW_CYCLES,  // clock-low timeout count
    parameter int IDLE_CYCLES = TSC_IDLE_CYCLES  // idle timeout count
) (
    input wire logic ref_clk,  // system clock, 25 MHz
    input wire logic reset,  // synchronous reset, active high
    input wire logic sclIn,  // bus clock level
    input wire logic sdaIn,  // bus data level
    output logic sdaOut,  // data drive value, always 0
    output logic sdaOe,  // high while pulling data low
    input wire logic timeoutEn,  // timeout control bit
    input wire logic [7:0] regRdata,  // data of requested register
    output tsc_reg_req_t regReq  // register access strobes
);
    // ************************************************************
    // bus sampling and condition detection
    // ************************************************************
    logic sclQ1_q, sdaQ1_q;  // previous line levels
    // inputs are synchronous, so one stage gives edges
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sclQ1_q <= 1'b1;
            sdaQ1_q <= 1'b1;
        end else begin
            sclQ1_q <= sclIn;
            sdaQ1_q <= sdaIn;
        end
    end
    logic sclRise, sclFall, startCond, stopCond;
    logic sclRisen_q;  // a clock rise was seen since the last start or counted fall
    assign sclRise = sclIn & ~sclQ1_q;
    // the fall that ends a start carries no bit, so only a fall that
    // follows a rise counts; otherwise every byte would end a bit early
    assign sclFall = ~sclIn & sclQ1_q & sclRisen_q;
    assign startCond = sclIn & sclQ1_q & sdaQ1_q & ~sdaIn;
    assign stopCond = sclIn & sclQ1_q & ~sdaQ1_q & sdaIn;
    // armed by each clock rise, disarmed by a start and by a counted fall
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sclRisen_q <= 1'b0;
        end else if (startCond) begin
            sclRisen_q <= 1'b0;  // start fall must not count as a bit
        end else if (sclRise) begin
            sclRisen_q <= 1'b1;
        end else if (sclFall) begin
            sclRisen_q <= 1'b0;
        end
    end

    // ************************************************************
    // timeout counters
    // ************************************************************
    logic [TSC_CNT_W-1:0] lowCnt_q, idleCnt_q;  // low and idle timers
    logic timeoutHit;  // protocol reset request
    // counters only run with the timeout bit; cleared otherwise
    always_ff @(posedge ref_clk) begin
        if (reset || !timeoutEn || sclIn) begin
            lowCnt_q <= '0;
        end else if (lowCnt_q != LOW_CYCLES[TSC_CNT_W-1:0]) begin
            lowCnt_q <= lowCnt_q + 1'b1;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (reset || !timeoutEn || !(sclIn && sdaIn)) begin
            idleCnt_q <= '0;
        end else if (idleCnt_q != IDLE_CYCLES[TSC_CNT_W-1:0]) begin
            idleCnt_q <= idleCnt_q + 1'b1;
        end
    end
    // a single cycle one below the limit fires; the counter then parks at the limit
    assign timeoutHit = (lowCnt_q == LOW_CYCLES[TSC_CNT_W-1:0] - 1'b1)
        || (idleCnt_q == IDLE_CYCLES[TSC_CNT_W-1:0] - 1'b1);

    // ************************************************************
    // protocol engine
    // ************************************************************
    tsc_state_t state_q;  // current protocol phase
    logic [7:0] shift_q;  // shift register, msb first
    logic [3:0] bitCnt_q;  // bits seen in current byte
    logic [7:0] ptr_q;  // register pointer
    logic firstByte_q;  // next received byte is the pointer
    logic ackPhase;  // ninth clock of a byte
    assign ackPhase = (bitCnt_q == TSC_ACK_BIT);
    logic hostAck_q;  // host acked last sent byte

    // state, bit count, shifter; runs at full clock so 400kHz is easy
    always_ff @(posedge ref_clk) begin
        if (reset || timeoutHit) begin
            state_q <= TSC_IDLE;
            bitCnt_q <= '0;
            shift_q <= '0;
            firstByte_q <= 1'b0;
            hostAck_q <= 1'b0;
        end else if (startCond) begin
            // start or repeated start, pointer is kept
            state_q <= TSC_ADDR;
            bitCnt_q <= '0;
        end else if (stopCond) begin
            state_q <= TSC_IDLE;
            bitCnt_q <= '0;
            firstByte_q <= 1'b0;
        end else begin
            case (state_q)
                TSC_ADDR, TSC_RXB: begin
                    if (sclRise && !ackPhase) begin
                        shift_q <= {shift_q[6:0], sdaIn};
                    end
                    if (sclFall) begin
                        if (ackPhase) begin
                            bitCnt_q <= '0;
                            if (state_q == TSC_ADDR) begin
                                // no count byte, any length
                                if (shift_q[0]) begin
                                    state_q <= TSC_TXB;
                                    shift_q <= regRdata;
                                end else begin
                                    state_q <= TSC_RXB;
                                    firstByte_q <= 1'b1;
                                end
                            end else begin
                                firstByte_q <= 1'b0;
                            end
                        end else if (bitCnt_q == 4'h7 &&
                                state_q == TSC_ADDR &&
                                shift_q[7:1] != TSC_DEV_ADDR) begin
                            // alert address is never matched
                            state_q <= TSC_SKIP;
                        end else begin
                            bitCnt_q <= bitCnt_q + 1'b1;
                        end
                    end
                end
                TSC_TXB: begin
                    if (sclRise && ackPhase) begin
                        hostAck_q <= ~sdaIn;
                    end
                    if (sclFall) begin
                        if (ackPhase) begin
                            bitCnt_q <= '0;
                            shift_q <= regRdata;
                            // a nack ends sending until the next start or stop
                            if (!hostAck_q) begin
                                state_q <= TSC_SKIP;
                            end
                        end else begin
                            bitCnt_q <= bitCnt_q + 1'b1;
                            shift_q <= {shift_q[6:0], 1'b0};
                        end
                    end
                end
                TSC_SKIP: begin
                    bitCnt_q <= '0;  // wait for start or stop
                end
                TSC_IDLE: begin
                    bitCnt_q <= '0;
                end
                default: begin
                    state_q <= TSC_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // register pointer and access strobes
    // ************************************************************
    logic rxDone;  // byte complete at ninth-clock fall, write side
    logic txDone;  // sent byte finished
    assign rxDone = (state_q == TSC_RXB) && sclFall && ackPhase;
    assign txDone = (state_q == TSC_TXB) && sclFall && ackPhase;
    // pointer survives stop so a later read reuses it
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            ptr_q <= TSC_PTR_RESET;
        end else if (rxDone && firstByte_q) begin
            ptr_q <= shift_q;
        end else if (rxDone || (txDone && hostAck_q)) begin
            // a nacked byte ends the read, so a lone read leaves the
            // pointer alone and can be repeated
            ptr_q <= ptr_q + 8'h01;
        end
    end
    // fetch strobe ahead of each sent byte, write strobe per data byte
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            regReq <= '0;
        end else begin
            regReq.wrEn <= rxDone && !firstByte_q;
            regReq.rdEn <= (state_q == TSC_ADDR) || (state_q == TSC_TXB);
            // a write lands at the pointer; while sending, the next
            // byte is fetched one place ahead so it is ready at the ack
            regReq.addr <= (rxDone && firstByte_q) ? shift_q :
                rxDone ? ptr_q :
                (state_q == TSC_TXB) ? ptr_q + 8'h01 : ptr_q;
            regReq.wdata <= shift_q;
        end
    end

    // ************************************************************
    // data line drive
    // ************************************************************
    // drive changes only after a clock fall so data holds while high
    always_ff @(posedge ref_clk) begin
        if (reset || timeoutHit || stopCond || startCond) begin
            sdaOe <= 1'b0;
        end else if (sclFall) begin
            if ((state_q == TSC_ADDR || state_q == TSC_RXB) &&
                    bitCnt_q == 4'h7 &&
                    !(state_q == TSC_ADDR &&
                      shift_q[7:1] != TSC_DEV_ADDR)) begin
                sdaOe <= 1'b1;  // ack on ninth clock
            end else if (state_q == TSC_ADDR && ackPhase &&
                    shift_q[0]) begin
                sdaOe <= ~regRdata[7];  // first bit of read data
            end else if (state_q == TSC_TXB && !ackPhase &&
                    bitCnt_q != 4'h7) begin
                sdaOe <= ~shift_q[6];
            end else if (txDone && hostAck_q) begin
                sdaOe <= ~regRdata[7];
            end else begin
                sdaOe <= 1'b0;  // released
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        sdaOut <= 1'b0;  // open drain: only ever pulls low
    end
endmodule

// ==== dv/tsc_client_monitor.sv ====
// port checks for the touch sensor serial client
`timescale 1ns/100ps
module tsc_client_monitor
    import tsc_pkg::*;
#(
    parameter int LOW_CYCLES = TSC_LOW_CYCLES  // clock-low timeout count
) (
    input wire logic ref_clk,  // system clock
    input wire logic reset,  // synchronous reset
    input wire logic sclIn,  // bus clock level
    input wire logic sdaOut,  // data drive value
    input wire logic sdaOe,  // data pull enable
    input wire logic timeoutEn,  // timeout control bit
    input wire tsc_reg_req_t regReq  // register strobes
);
    logic [TSC_CNT_W-1:0] lowCnt_q;  // cycles of clock low with timeout on
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    // saturating count, cleared whenever the clock is high
    always_ff @(posedge ref_clk) begin
        if (reset || sclIn || !timeoutEn)
            lowCnt_q <= '0;
        else if (lowCnt_q != '1)
            lowCnt_q <= lowCnt_q + 1'b1;
    end
    // an ack already settled while the clock stays low
    sequence ackSettled;
        (!sclIn) [*3] ##0 (sdaOe && !timeoutEn);
    endsequence
    a_out_zero: assert property (sdaOut == 1'b0)
        else $error("data drive value not low");
    a_oe_scl_low: assert property ($changed(sdaOe) |-> !sclIn)
        else $error("data pull changed while clock high");
    a_oe_hold: assert property ($rose(sdaOe) |=> sdaOe [*4])
        else $error("data pull too short");
    a_wr_pulse: assert property (regReq.wrEn |=> !regReq.wrEn)
        else $error("write strobe longer than one cycle");
    a_fetch_no_write: assert property (
        regReq.wrEn |-> !regReq.rdEn)
        else $error("fetch and write strobes raised together");
    a_wr_scl_low: assert property (
        regReq.wrEn |-> !sclIn && !$past(sclIn))
        else $error("write strobe outside clock low");
    a_wr_after_ack: assert property (
        regReq.wrEn |-> $past(sdaOe) || $past(sdaOe, 2))
        else $error("write strobe without ack");
    a_keep_no_tmo: assert property (ackSettled |=> sdaOe)
        else $error("ack dropped with timeout off");
    a_low_release: assert property (
        lowCnt_q > LOW_CYCLES + 4 |-> !sdaOe)
        else $error("clock-low timeout did not release data");
endmodule

// ==== dv/tsc_host_model.sv ====
// bus master model driving the client's clock and data lines
`timescale 1ns/100ps
module tsc_host_model #(
    parameter int QTR = 16  // quarter bit in cycles, near 390 kHz
) (
    input wire logic ref_clk,  // bench clock
    input wire logic sdaOe,  // client pulls data low
    output logic sclIn,  // bus clock, stands high outside frames
    output logic sdaIn  // resolved data wire
);
    logic sdaDrv = 1'b1;  // master drive, 1 means released
    initial sclIn = 1'b1;
    // pull-up wire: low whenever either party pulls
    assign sdaIn = sdaDrv & ~sdaOe;
    task automatic wt(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // data changes only while clock low; hold stretches the high phase
    task automatic sendBit(input logic b, input int hold, output logic s);
        sdaDrv = b;
        wt(QTR);
        sclIn = 1'b1;
        wt(QTR + hold);
        s = sdaIn;
        wt(QTR);
        sclIn = 1'b0;
        wt(QTR);
    endtask
    // start or repeated start: data falls while clock high
    task automatic start();
        sdaDrv = 1'b1;
        wt(QTR);
        sclIn = 1'b1;
        wt(QTR);
        sdaDrv = 1'b0;
        wt(QTR);
        sclIn = 1'b0;
        wt(QTR);
    endtask
    // stop: data rises while clock high, bus then idles
    task automatic stop();
        sdaDrv = 1'b0;
        wt(QTR);
        sclIn = 1'b1;
        wt(QTR);
        sdaDrv = 1'b1;
        wt(4 * QTR);
    endtask
    // msb first, ninth bit from ackIn, no count byte
    task automatic xfer(input logic [7:0] d, input logic ackIn,
                        output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--)
            sendBit(d[i], 0, q[i]);
        sendBit(ackIn, 0, ack);
    endtask
endmodule

// ==== dv/tb_touch_sensor_serial_client.sv ====
// self-checking bench for the touch sensor serial client
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin testsRun++; if ((got) !== (ex)) begin \
    errTotal++; $display("mismatch %s exp %h got %h", nm, ex, got); end end
module tb_touch_sensor_serial_client
    import tsc_pkg::*;
;
    localparam logic [7:0] WR = {TSC_DEV_ADDR, 1'b0};  // write address byte
    localparam logic [7:0] RD = {TSC_DEV_ADDR, 1'b1};  // read address byte
    localparam int TMO = 60;  // shortened timeouts, above a bit phase
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic timeoutEn = 1'b0;
    logic sclIn, sdaIn, sdaOut, sdaOe, ak;
    logic [7:0] regRdata, q;
    logic [7:0] mem [256];  // register space behind the client
    tsc_reg_req_t regReq;
    int errTotal = 0;
    int testsRun = 0;
    int cycles = 0;
    tsc_client #(.LOW_CYCLES(TMO), .IDLE_CYCLES(TMO)) i_dut (
        .ref_clk(ref_clk), .reset(reset), .sclIn(sclIn), .sdaIn(sdaIn),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .timeoutEn(timeoutEn),
        .regRdata(regRdata), .regReq(regReq));
    tsc_host_model i_host (.ref_clk(ref_clk), .sdaOe(sdaOe),
        .sclIn(sclIn), .sdaIn(sdaIn));
    assign regRdata = mem[regReq.addr];
    always @(posedge ref_clk) begin
        if (regReq.wrEn)
            mem[regReq.addr] <= regReq.wdata;
        cycles++;
        if (cycles == 40000) begin  // hang guard
            errTotal++;
            wrapUp();
        end
    end
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic wrapUp();
        $display("comparisons %0d mismatches %0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wb(input logic [7:0] d);
        i_host.xfer(d, 1'b1, q, ak);
        `CHK("ack", 1'b0, ak)
    endtask
    // block write across the top of the space: pointer wraps
    task automatic sWriteBlock();
        i_host.start();
        wb(WR);
        wb(8'hFE);
        wb(8'hA1);
        wb(8'hB2);
        wb(8'hC3);
        i_host.stop();
        `CHK("wr0", 8'hA1, mem[8'hFE])
        `CHK("wr1", 8'hB2, mem[8'hFF])
        `CHK("wr2", 8'hC3, mem[8'h00])
    endtask
    // read with restart, acked bytes advance and wrap, last nacked
    task automatic sReadBlock();
        i_host.start();
        wb(WR);
        wb(8'hFF);
        i_host.start();
        wb(RD);
        i_host.xfer(8'hFF, 1'b0, q, ak);
        `CHK("rd0", 8'hB2, q)
        i_host.xfer(8'hFF, 1'b0, q, ak);
        `CHK("rd1", 8'hC3, q)
        i_host.xfer(8'hFF, 1'b1, q, ak);
        `CHK("rd2", 8'h5B, q)
        i_host.stop();
    endtask
    // foreign and alert-response addresses get no answer
    task automatic sOtherAddr(input logic [6:0] a);
        i_host.start();
        i_host.xfer({a, 1'b1}, 1'b1, q, ak);
        `CHK("nack", 1'b1, ak)
        i_host.xfer(8'hFF, 1'b1, q, ak);
        `CHK("released", 8'hFF, q)
        i_host.stop();
    endtask
    // pointer-only write, then two plain reads of the same place
    task automatic sPointerOnly();
        i_host.start();
        wb(WR);
        wb(8'h10);
        i_host.stop();
        `CHK("nowrite", 8'h4A, mem[8'h10])
        repeat (2) begin
            i_host.start();
            wb(RD);
            i_host.xfer(8'hFF, 1'b1, q, ak);
            `CHK("reread", 8'h4A, q)
            i_host.stop();
        end
    endtask
    // clock held low during the address ack
    task automatic sLowHold(input logic en, input logic exp);
        timeoutEn = en;
        i_host.start();
        for (int i = 7; i >= 0; i--)
            i_host.sendBit(WR[i], 0, ak);
        i_host.wt(TMO + 10);
        `CHK("oe", exp, sdaOe)
        i_host.sendBit(1'b1, 0, ak);
        i_host.stop();
        timeoutEn = 1'b0;
    endtask
    // both lines high mid-byte; an idle reset drops the ack
    task automatic sIdle(input logic en, input logic exp);
        timeoutEn = en;
        i_host.start();
        wb(WR);
        i_host.sendBit(1'b1, TMO + 10, ak);
        for (int i = 0; i < 7; i++)
            i_host.sendBit(1'b0, 0, ak);
        i_host.sendBit(1'b1, 0, ak);
        `CHK("idle", exp, ak)
        i_host.stop();
        timeoutEn = 1'b0;
    endtask
    initial begin
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(i) ^ 8'h5A;
        repeat (8) @(negedge ref_clk);
        reset = 1'b0;
        i_host.wt(4);
        sWriteBlock();
        sReadBlock();
        sOtherAddr(7'h0C);
        sOtherAddr(7'h29);
        sPointerOnly();
        sLowHold(1'b0, 1'b1);
        sLowHold(1'b1, 1'b0);
        sIdle(1'b0, 1'b0);
        sIdle(1'b1, 1'b1);
        wrapUp();
    end
endmodule
bind tsc_client tsc_client_monitor #(.LOW_CYCLES(LOW_CYCLES)) i_mon (
    .ref_clk(ref_clk), .reset(reset), .sclIn(sclIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .timeoutEn(timeoutEn), .regReq(regReq));
